// ==== smw_pkg.sv ====
// Types and span arithmetic for the static memory wait-state sequencer.
// Assumes smw_regs.svh supplies the widths.
`include "smw_regs.svh"

package smw_pkg;

    typedef enum logic [1:0] {SMW_IDLE, SMW_ACTIVE, SMW_HOLD, SMW_CAPT}
        smw_state_t;

    typedef struct packed {
        logic write;
        logic [`SMW_ADDR_W-1:0] addr;
        logic [`SMW_DATA_W-1:0] wdata;
        logic [`SMW_LANES-1:0] lanes;
    } smw_req_t;

    typedef struct packed {
        logic [`SMW_FIELD_W-1:0] output_enable_delay;
        logic [`SMW_FIELD_W-1:0] read_wait_count;
        logic [`SMW_FIELD_W-1:0] write_enable_delay;
        logic [`SMW_FIELD_W-1:0] write_wait_count;
        logic read_delay_ext;
    } smw_cfg_t;

    // Strobe length last - first + 1 - ext, never below one cycle.
    function automatic logic [`SMW_CNT_W-1:0] smw_span(
        input logic [`SMW_FIELD_W-1:0] last,
        input logic [`SMW_FIELD_W-1:0] first,
        input logic ext
    );
        logic [`SMW_CNT_W-1:0] d;
        d = `SMW_CNT_W'(last) - `SMW_CNT_W'(first) + `SMW_CNT_ONE
            - `SMW_CNT_W'(ext);
        if (last < first || d == `SMW_CNT_ZERO)
        begin
            d = `SMW_CNT_ONE;
        end
        return d;
    endfunction : smw_span

endpackage : smw_pkg

// ==== smw_regs.svh ====
// Constants for the static memory wait-state sequencer.
// Assumes one bus clock; all counts below are in whole bus clock cycles.
// Function
// (R1) Output enable follows chip select by delay
// (R2) Byte lanes follow chip select by delay
// (R3) Address leads output enable by delay
// (R4) Output enable lasts read wait minus delay plus one
// (R5) No enable pulse shorter than one cycle
// (R6) Read wait below delay: all switch together
// (R7) Strobe delay never exceeds read wait
// (R8) Extension bit adds one cycle before enable
// (R9) Extension bit shortens enable by one cycle
// (R10) Write enable after chip select: delay plus one
// (R11) Write enable lasts write wait minus delay plus one
// (R12) Write data valid before write enable
// (R13) Write byte lanes last pulse plus two, min three
// (R14) Address held one cycle after write enable
// (R15) Data held one cycle after write enable
// (R16) Address held one cycle after byte lanes
// (R17) Data held one cycle after write byte lanes
// (R18) Chip select releases no earlier than strobes
// (R19) Wait fields latched at each access start
`ifndef SMW_REGS_SVH
`define SMW_REGS_SVH

`define SMW_FIELD_W 5
`define SMW_CNT_W 7
`define SMW_ADDR_W 24
`define SMW_DATA_W 16
`define SMW_LANES 2
`define SMW_STROBE_OFF 1'b1
`define SMW_CNT_ZERO 7'h00
`define SMW_CNT_ONE 7'h01
`define SMW_WR_TAIL 7'h01
`define SMW_WR_LANE_EXTRA 7'h02

`endif

// ==== smw_sram_model.sv ====
// Behavioural static memory of sixteen words on the sequencer's pins.
// Assumes active-low strobes; a released data bus reads back inverted.
`timescale 1ns/1ps
`include "smw_regs.svh"

module smw_sram_model
(
    // Clock
    input wire logic clk_in,
    // Memory pins
    input wire logic cs_n_in,
    input wire logic oe_n_in,
    input wire logic we_n_in,
    input wire logic [`SMW_LANES-1:0] bl_n_in,
    input wire logic [`SMW_ADDR_W-1:0] addr_in,
    input wire logic [`SMW_DATA_W-1:0] data_in,
    output logic [`SMW_DATA_W-1:0] data_out
);
    logic [`SMW_DATA_W-1:0] mem [16];
    logic [`SMW_DATA_W-1:0] last_ff = 16'h0000;
    wire logic rd_on = !cs_n_in && !oe_n_in;

    // An idle bus toggles so that a stale sample cannot pass as data.
    assign data_out = rd_on ? mem[addr_in[3:0]] : ~last_ff;

    always @(posedge clk_in)
    begin
        last_ff <= data_out;
        if (!cs_n_in && !we_n_in && !bl_n_in[0])
            mem[addr_in[3:0]][7:0] <= data_in[7:0];
        if (!cs_n_in && !we_n_in && !bl_n_in[1])
            mem[addr_in[3:0]][15:8] <= data_in[15:8];
    end
endmodule : smw_sram_model

// ==== smw_static_seq.sv ====
// Static memory cycle sequencer: one access per request, pins registered.
// Assumes request and configuration come from logic on clk_in; only the
// memory data bus is asynchronous and is synchronised.
`timescale 1ns/1ps
`include "smw_regs.svh"

module smw_static_seq
    import smw_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Configuration
    input wire smw_cfg_t cfg_in,
    // Request side
    input wire logic req_valid_in,
    input wire smw_req_t req_in,
    output logic req_ready_out,
    output logic done_out,
    output logic [`SMW_DATA_W-1:0] rdata_out,
    // Memory pins
    output logic chip_select_n_out,
    output logic output_enable_n_out,
    output logic write_enable_n_out,
    output logic [`SMW_LANES-1:0] byte_lane_select_n_out,
    output logic [`SMW_ADDR_W-1:0] addr_out,
    output logic [`SMW_DATA_W-1:0] data_out,
    output logic data_oe_out,
    input wire logic [`SMW_DATA_W-1:0] data_in
);

    localparam int CW = `SMW_CNT_W;

    smw_state_t state_ff, nxt_state;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic wr_ff;
    logic [`SMW_LANES-1:0] lanes_ff;
    logic [CW-1:0] lane_on_ff, strb_on_ff, strb_off_ff, end_ff;
    logic [CW-1:0] rd_lim_ff, pulse_ff;
    logic [`SMW_DATA_W-1:0] sync1_ff, sync2_ff;
    logic done_ff;

    wire accept = req_valid_in && state_ff == SMW_IDLE;
    wire [CW-1:0] oen = CW'(cfg_in.output_enable_delay);
    wire [CW-1:0] rdw = CW'(cfg_in.read_wait_count);
    wire [CW-1:0] wen = CW'(cfg_in.write_enable_delay);
    wire rd_ordered = cfg_in.read_wait_count >= cfg_in.output_enable_delay;
    wire ext = cfg_in.read_delay_ext;

    // Read strobe start: delay plus extension, capped by the read wait; zero when the read wait is below the delay.
    wire [CW-1:0] rd_raw = oen + CW'(ext); // R8
    wire [CW-1:0] rd_on = !rd_ordered ? `SMW_CNT_ZERO : // R6
        (rd_raw > rdw ? rdw : rd_raw); // R7
    wire [CW-1:0] rd_len = rd_ordered ?
        smw_span(cfg_in.read_wait_count, cfg_in.output_enable_delay,
                 ext) : // R4 R9 R5
        rdw + `SMW_CNT_ONE; // R6
    wire [CW-1:0] wr_len = smw_span(cfg_in.write_wait_count,
        cfg_in.write_enable_delay, 1'b0); // R11 R5
    wire [CW-1:0] we_on = wen + `SMW_CNT_ONE; // R10
    wire [CW-1:0] we_off = we_on + wr_len;
    wire [CW-1:0] wr_end = we_off + `SMW_WR_TAIL; // R13 R14 R15

    wire last_cycle = cnt_ff == end_ff - `SMW_CNT_ONE;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            SMW_IDLE:
            begin
                nxt_cnt = `SMW_CNT_ZERO;
                if (req_valid_in)
                begin
                    nxt_state = SMW_ACTIVE;
                end
            end
            SMW_ACTIVE:
            begin
                nxt_cnt = cnt_ff + `SMW_CNT_ONE;
                if (last_cycle)
                begin
                    nxt_state = SMW_HOLD;
                end
            end
            SMW_HOLD:
            begin
                nxt_state = wr_ff ? SMW_IDLE : SMW_CAPT;
            end
            SMW_CAPT:
            begin
                nxt_state = SMW_IDLE;
            end
            default:
            begin
                nxt_state = SMW_IDLE;
            end
        endcase
    end

    wire [CW-1:0] lane_on_sel = accept ?
        (req_in.write ? wen : rd_on) : lane_on_ff;
    wire [CW-1:0] strb_on_sel = accept ?
        (req_in.write ? we_on : rd_on) : strb_on_ff;
    wire [CW-1:0] strb_off_sel = accept ?
        (req_in.write ? we_off : rd_on + rd_len) : strb_off_ff;
    wire [`SMW_LANES-1:0] lanes_sel = accept ? req_in.lanes : lanes_ff;

    // Pin levels follow the next state so they line up with the counter.
    wire nxt_act = nxt_state == SMW_ACTIVE;
    wire nxt_lane = nxt_act && nxt_cnt >= lane_on_sel;
    wire nxt_strb = nxt_act && nxt_cnt >= strb_on_sel &&
        nxt_cnt < strb_off_sel;
    wire nxt_wr = accept ? req_in.write : wr_ff;
    wire nxt_drive = nxt_wr && (nxt_act || nxt_state == SMW_HOLD);

    assign req_ready_out = state_ff == SMW_IDLE;
    assign done_out = done_ff;

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            state_ff <= SMW_IDLE;
            cnt_ff <= `SMW_CNT_ZERO;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // Timing is frozen per access so mid-access config writes cannot
    // tear a cycle.
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            wr_ff <= 1'b0;
            lanes_ff <= '0;
            lane_on_ff <= `SMW_CNT_ZERO;
            strb_on_ff <= `SMW_CNT_ZERO;
            strb_off_ff <= `SMW_CNT_ONE;
            end_ff <= `SMW_CNT_ONE;
            rd_lim_ff <= `SMW_CNT_ZERO;
            pulse_ff <= `SMW_CNT_ONE;
            addr_out <= '0;
            data_out <= '0;
        end
        else if (accept)
        begin
            wr_ff <= req_in.write; // R19
            lanes_ff <= req_in.lanes;
            lane_on_ff <= lane_on_sel;
            strb_on_ff <= strb_on_sel;
            strb_off_ff <= strb_off_sel;
            end_ff <= req_in.write ? wr_end : rd_on + rd_len; // R18
            rd_lim_ff <= rdw;
            pulse_ff <= req_in.write ? wr_len : rd_len;
            addr_out <= req_in.addr; // R3 R16
            data_out <= req_in.wdata; // R12 R17
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            chip_select_n_out <= `SMW_STROBE_OFF;
            output_enable_n_out <= `SMW_STROBE_OFF;
            write_enable_n_out <= `SMW_STROBE_OFF;
            byte_lane_select_n_out <= '1;
            data_oe_out <= 1'b0;
        end
        else
        begin
            chip_select_n_out <= !nxt_act; // R18
            output_enable_n_out <= !(nxt_strb && !nxt_wr); // R1
            write_enable_n_out <= !(nxt_strb && nxt_wr); // R10
            byte_lane_select_n_out <= nxt_lane ? ~lanes_sel : '1; // R2 R13
            data_oe_out <= nxt_drive; // R15 R17
        end
    end

    // Read data is captured two edges after the strobe closes.
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            rdata_out <= '0;
            done_ff <= 1'b0;
        end
        else
        begin
            sync1_ff <= data_in;
            sync2_ff <= sync1_ff;
            done_ff <= state_ff == SMW_CAPT ||
                (state_ff == SMW_HOLD && wr_ff);
            if (state_ff == SMW_CAPT)
            begin
                rdata_out <= sync2_ff;
            end
        end
    end

    // Helper: length of the current byte lane low phase.
    logic [CW-1:0] lane_len_ff;
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            lane_len_ff <= `SMW_CNT_ZERO;
        end
        else
        begin
            lane_len_ff <= (&byte_lane_select_n_out) ? `SMW_CNT_ZERO :
                lane_len_ff + `SMW_CNT_ONE;
        end
    end

    sequence strobe_close_s;
        $rose(write_enable_n_out) ##0 data_oe_out;
    endsequence

    sequence addr_hold_s;
        $stable(addr_out) ##1 $stable(addr_out);
    endsequence

    oe_after_cs_a: assert property (@(posedge clk_in) // R1
        disable iff (sys_rst_in)
        $fell(output_enable_n_out) |-> cnt_ff == strb_on_ff &&
            !chip_select_n_out)
        else $error("Output enable fell at the wrong cycle.");

    lane_with_oe_a: assert property (@(posedge clk_in) // R2
        disable iff (sys_rst_in)
        $fell(output_enable_n_out) |-> !(&byte_lane_select_n_out))
        else $error("Byte lanes not active with output enable.");

    oe_width_a: assert property (@(posedge clk_in) // R4
        disable iff (sys_rst_in)
        $rose(output_enable_n_out) |-> lane_len_ff == pulse_ff)
        else $error("Output enable width differs from programmed.");

    pulse_min_a: assert property (@(posedge clk_in) // R5
        disable iff (sys_rst_in)
        state_ff == SMW_ACTIVE |-> strb_off_ff > strb_on_ff)
        else $error("Strobe pulse would be empty.");

    oe_delay_cap_a: assert property (@(posedge clk_in) // R7
        disable iff (sys_rst_in)
        $fell(output_enable_n_out) |-> cnt_ff <= rd_lim_ff)
        else $error("Output enable delay exceeds read wait.");

    we_after_cs_a: assert property (@(posedge clk_in) // R10
        disable iff (sys_rst_in)
        $fell(write_enable_n_out) |-> cnt_ff == strb_on_ff &&
            cnt_ff >= `SMW_CNT_ONE && $past(data_oe_out))
        else $error("Write enable timing or data setup wrong.");

    write_lanes_a: assert property (@(posedge clk_in) // R13
        disable iff (sys_rst_in)
        $rose(&byte_lane_select_n_out) && wr_ff |->
            lane_len_ff == pulse_ff + `SMW_WR_LANE_EXTRA)
        else $error("Write byte lane width wrong.");

    we_hold_a: assert property (@(posedge clk_in) // R14
        disable iff (sys_rst_in)
        strobe_close_s |-> addr_hold_s ##0 data_oe_out)
        else $error("Address or data not held after write enable.");

    lane_hold_a: assert property (@(posedge clk_in) // R16
        disable iff (sys_rst_in)
        $rose(&byte_lane_select_n_out) |-> $stable(addr_out) ##0
            (data_oe_out || !wr_ff))
        else $error("Hold after byte lanes violated.");

    cs_last_a: assert property (@(posedge clk_in) // R18
        disable iff (sys_rst_in)
        chip_select_n_out |-> output_enable_n_out &&
            write_enable_n_out && (&byte_lane_select_n_out))
        else $error("Chip select released before a strobe.");

    // Helper: length of the current write enable low phase.
    logic [CW-1:0] we_len_ff;
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            we_len_ff <= `SMW_CNT_ZERO;
        end
        else
        begin
            we_len_ff <= write_enable_n_out ? `SMW_CNT_ZERO :
                we_len_ff + `SMW_CNT_ONE;
        end
    end

    we_width_a: assert property (@(posedge clk_in) // R11
        disable iff (sys_rst_in)
        $rose(write_enable_n_out) |-> we_len_ff == pulse_ff)
        else $error("Write enable width differs from programmed.");

    oe_with_cs_a: assert property (@(posedge clk_in) // R6
        disable iff (sys_rst_in)
        $fell(chip_select_n_out) && !wr_ff &&
            strb_on_ff == `SMW_CNT_ZERO |->
            !output_enable_n_out && !(&byte_lane_select_n_out))
        else $error("Read strobes did not start with chip select.");

endmodule : smw_static_seq

// ==== static_memory_wait_timing_tb.sv ====
// Self-checking bench for the static memory wait-state sequencer.
// Assumes smw_sram_model stands on the memory pins of the sequencer.
`timescale 1ns/1ps
`include "smw_regs.svh"

module static_memory_wait_timing_tb
    import smw_pkg::*;
;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    smw_cfg_t cfg = '0;
    logic req_valid = 1'b0;
    smw_req_t req = '0;
    logic ready, done, cs_n, oe_n, we_n, doe;
    logic [1:0] bl_n;
    logic [23:0] addr;
    logic [15:0] rdata, dout, din;
    int err_count = 0;
    int num_checks = 0;

    always #12.5 clk_in = ~clk_in;

    smw_static_seq dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .cfg_in(cfg), .req_valid_in(req_valid), .req_in(req),
        .req_ready_out(ready), .done_out(done), .rdata_out(rdata),
        .chip_select_n_out(cs_n), .output_enable_n_out(oe_n),
        .write_enable_n_out(we_n), .byte_lane_select_n_out(bl_n),
        .addr_out(addr), .data_out(dout), .data_oe_out(doe),
        .data_in(din));
    smw_sram_model mem (.clk_in(clk_in), .cs_n_in(cs_n), .oe_n_in(oe_n),
        .we_n_in(we_n), .bl_n_in(bl_n), .addr_in(addr), .data_in(dout),
        .data_out(din));

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
            err_count++;
        end
    endtask : check

    task automatic report_and_stop;
        $display("Checks %0d, errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    // One access; edges are counted from the first chip-select cycle.
    task automatic run(input logic wr, input int a, input int b,
        input int ext, input logic [3:0] ad, input logic [15:0] wd,
        input logic [1:0] ln);
        int k = -1, kd = -1, n_cs = 0, n_oe = 0, n_we = 0, n_bl = 0;
        int f_oe = 99, f_we = 99, f_bl = 99, on, len;
        check("ready", ready, 1);
        cfg = '{a[4:0], b[4:0], a[4:0], b[4:0], ext[0]};
        req = '{wr, {20'h00000, ad}, wd, ln};
        req_valid = 1'b1;
        @(negedge clk_in);
        req_valid = 1'b0;
        for (int n = 0; n < 80 && kd < 0; n++)
        begin
            if (k >= 0 || cs_n === 1'b0)
                k++;
            if (k >= 0)
                check("addr", addr, ad);
            if (wr && k >= 0 && done !== 1'b1)
                check("wdata", {doe, dout}, {1'b1, wd});
            if (bl_n !== 2'b11)
                check("lanes", bl_n, 2'(~ln));
            n_cs += int'(cs_n === 1'b0);
            n_oe += int'(oe_n === 1'b0);
            n_we += int'(we_n === 1'b0);
            n_bl += int'(bl_n !== 2'b11);
            if (oe_n === 1'b0 && f_oe > k)
                f_oe = k;
            if (we_n === 1'b0 && f_we > k)
                f_we = k;
            if (bl_n !== 2'b11 && f_bl > k)
                f_bl = k;
            if (done === 1'b1)
                kd = k;
            @(negedge clk_in);
        end
        if (kd < 0)
        begin
            err_count++;
            report_and_stop;
        end
        if (wr)
        begin
            len = (b >= a && b - a + 1 > 1) ? b - a + 1 : 1;
            check("we_at", f_we, a + 1);
            check("we_len", n_we, len);
            check("bl_at", f_bl, a);
            check("bl_len", n_bl, len + 2);
            check("cs_len", n_cs, a + len + 2);
            check("done_at", kd, a + len + 3);
            check("oe_len", n_oe, 0);
        end
        else
        begin
            on = (b < a) ? 0 : (a + ext > b) ? b : a + ext;
            len = (b < a) ? b + 1 : (b - a + 1 - ext > 1) ? b - a + 1 - ext : 1;
            check("oe_at", f_oe, on);
            check("oe_len", n_oe, len);
            check("bl_at", f_bl, on);
            check("bl_len", n_bl, len);
            check("cs_len", n_cs, on + len);
            check("done_at", kd, on + len + 2);
            check("rdata", rdata, wd);
            check("we_len", n_we, 0);
        end
    endtask : run

    task automatic sc_reset;
        check("rst_pins", {cs_n, oe_n, we_n, bl_n, doe, done, ready}, 8'hF9);
        check("rst_addr", addr, 0);
    endtask : sc_reset

    // Writes: plain, long delay, wait below delay, all zero.
    task automatic sc_writes;
        run(1'b1, 0, 1, 0, 4'h1, 16'hA55A, 2'b11);
        run(1'b1, 2, 4, 0, 4'h2, 16'h3C96, 2'b11);
        run(1'b1, 3, 1, 0, 4'h1, 16'h7E81, 2'b01);
        run(1'b1, 0, 0, 0, 4'h3, 16'h1234, 2'b11);
    endtask : sc_writes

    // Reads back to back with a new setting each time.
    task automatic sc_reads;
        run(1'b0, 1, 3, 0, 4'h1, 16'hA581, 2'b11);
        run(1'b0, 0, 0, 0, 4'h2, 16'h3C96, 2'b11);
        run(1'b0, 3, 1, 0, 4'h3, 16'h1234, 2'b11);
    endtask : sc_reads

    // Extension bit, with the wait equal to and above the delay.
    task automatic sc_read_ext;
        run(1'b0, 2, 2, 1, 4'h2, 16'h3C96, 2'b11);
        run(1'b0, 2, 5, 1, 4'h1, 16'hA581, 2'b11);
        run(1'b0, 0, 3, 1, 4'h3, 16'h1234, 2'b10);
    endtask : sc_read_ext

    // Reset in the middle of a write: pins go idle, the next read works.
    task automatic sc_mid_reset;
        cfg = '{5'h02, 5'h04, 5'h02, 5'h04, 1'b0};
        req = '{1'b1, 24'h000004, 16'h5AA5, 2'b11};
        req_valid = 1'b1;
        @(negedge clk_in);
        req_valid = 1'b0;
        check("mid_cs", cs_n, 0);
        repeat (3) @(negedge clk_in);
        sys_rst_in = 1'b1;
        @(negedge clk_in);
        sc_reset;
        sys_rst_in = 1'b0;
        @(negedge clk_in);
        run(1'b0, 0, 0, 0, 4'h3, 16'h1234, 2'b11);
    endtask : sc_mid_reset

    initial
    begin
        repeat (6) @(negedge clk_in);
        sc_reset;
        sys_rst_in = 1'b0;
        @(negedge clk_in);
        sc_writes;
        sc_reads;
        sc_read_ext;
        sc_mid_reset;
        report_and_stop;
    end
endmodule : static_memory_wait_timing_tb
